// *** include/amp_ctrl_pkg.sv ***
// Package: constants and types for the amplifier two-wire control port
package amp_ctrl_pkg;
  // Device address: upper seven bits of the address byte (D8H with the R/W bit clear)
  localparam logic [6:0] DEV_ADDR7        = 7'h6C;
  // Sub-address layout
  localparam int         SUB_AUTOINC_BIT  = 7;      // Page mode enable
  localparam logic [6:0] SUB_CHANNEL_CTRL = 7'h01;  // channel_control_settings
  localparam logic [6:0] SUB_SYSTEM_CTRL  = 7'h02;  // system_control_settings
  // Field positions of channel_control_settings
  localparam int         CH_CLIP_10PCT    = 0;
  localparam int         CH_REAR_PLAY     = 1;
  localparam int         CH_FRONT_PLAY    = 2;
  localparam int         CH_REAR_GAIN12   = 3;
  localparam int         CH_FRONT_GAIN12  = 4;
  localparam int         CH_OFFSET_EN     = 5;
  localparam int         CH_DIAG_EN       = 6;
  localparam int         CH_TURNON_REPEAT = 7;
  // Field positions of system_control_settings
  localparam int         SYS_STANDBY_OFF  = 4;
  localparam int         SYS_CLIP_TO_OFS  = 5;
  localparam int         SYS_FAST_MUTE    = 6;
  // Values after reset, and the last bit index
  localparam logic [7:0] CTRL_RESET_VAL   = 8'h00;
  localparam logic [2:0] BIT_CNT_LAST     = 3'h7;
  localparam logic [2:0] BIT_CNT_ZERO     = 3'h0;

  // Serial port states, one-hot
  typedef enum logic [7:0] {
    BUS_IDLE   = 8'h01,  // Waiting for a start condition
    BUS_ADDR   = 8'h02,  // Shifting in the address byte
    BUS_ACK    = 8'h04,  // Holding our acknowledge low
    BUS_SUB    = 8'h08,  // Shifting in the sub-address
    BUS_DATA   = 8'h10,  // Shifting in a control byte
    BUS_TX     = 8'h20,  // Shifting out a status byte
    BUS_RACK   = 8'h40,  // Sampling the master acknowledge
    BUS_IGNORE = 8'h80   // Not addressed, wait for start or stop
  } bus_state_t;

  // Power-up states, one-hot
  typedef enum logic [3:0] {
    PWR_HW_STANDBY = 4'h1,  // Logic supply off, port deaf
    PWR_SW_STANDBY = 4'h2,  // Logic up, port live, amplifier off
    PWR_CHARGE     = 4'h4,  // Ripple node charging
    PWR_RUN        = 4'h8   // Full operation
  } pwr_state_t;
endpackage

// *** hw/pin_edge_track.sv ***
// Pin tracker: registers a bus pin and reports its edges
`timescale 1ns/100ps
`default_nettype none
module pin_edge_track (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  import amp_ctrl_pkg::*;
  logic cur_r;   // Current sampled level
  logic prev_r;  // Level one cycle earlier

  // Bus idles high, so both stages reset high to avoid a false edge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cur_r  <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      cur_r  <= pin_in;
      prev_r <= cur_r;
    end
  end

  assign level = cur_r;
  assign rise  = cur_r & ~prev_r;
  assign fall  = ~cur_r & prev_r;
endmodule
`default_nettype wire

// *** hw/ctrl_byte_reg.sv ***
// Control byte register: eight write-only setting bits
`timescale 1ns/100ps
`default_nettype none
module ctrl_byte_reg (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] value
);
  import amp_ctrl_pkg::*;
  logic [7:0] value_r;  // Stored settings

  // Clears at reset so the amplifier starts muted and in standby
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      value_r <= CTRL_RESET_VAL;
    end else if (wr_en) begin
      value_r <= wr_data;
    end
  end

  assign value = value_r;
endmodule
`default_nettype wire

// *** hw/amp_i2c_control_port.sv ***
// Top: two-wire control port, control bytes and start-up sequencing
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Sub-address bit 7 enables auto increment
// - Sub-address 01H/02H pick the control byte
// - First byte bit0 sets clip threshold 10%
// - First byte bit1 releases rear pair mute
// - First byte bit2 releases front pair mute
// - First byte bit3 sets rear gain 12dB
// - First byte bit4 sets front gain 12dB
// - First byte bit5 enables offset detection
// - First byte bit6 enables diagnosis cycle
// - First byte bit7 selects repeated turn-on diagnosis
// - Second byte D6 issues fast mute
// - Port live only after clip pin powered
// - Standby off charges ripple, then runs
// - After start-up, clip pin outputs clip detection, or offset detection when second byte bit5 is set
// - Second byte bit4 leaves standby for play
// - Auto increment writes first then second byte
module amp_i2c_control_port (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic scl_in,           // Bus clock from the master
  input  wire logic sda_in,           // Bus data level
  output logic      sda_out,          // Data drive value, always low
  output logic      sda_oe,           // High while pulling data low
  input  wire logic clip_pin_in,      // Level on clipping_indicator_pin
  output logic      clip_pin_out,     // Drive value for clipping_indicator_pin
  output logic      clip_pin_oe,      // High while pulling the clip pin low
  input  wire logic clip_event,       // Analog clip detector
  input  wire logic offset_event,     // Analog offset detector
  input  wire logic ripple_at_target, // Ripple node reached its level
  output logic      ripple_charge,    // Start charging the ripple node
  output logic      amp_run,          // Full operation
  output logic      clip_thresh_10pct,
  output logic      rear_play,
  output logic      front_play,
  output logic      rear_gain_12db,
  output logic      front_gain_12db,
  output logic      offset_det_en,
  output logic      diag_cycle_en,
  output logic      turnon_repeat,
  output logic      fast_mute
);
  import amp_ctrl_pkg::*;

  // Pin sampling
  logic scl_lvl;   // Registered clock level
  logic scl_rise;  // Clock rising edge
  logic scl_fall;  // Clock falling edge
  logic sda_lvl;   // Registered data level
  logic sda_rise;  // Data rising edge
  logic sda_fall;  // Data falling edge

  // Serial engine state
  bus_state_t bus_r;        // Engine state
  bus_state_t ack_next_r;   // State entered when our acknowledge ends
  logic [2:0] bit_cnt_r;    // Bit index within the byte
  logic [7:0] shift_r;      // Receive shifter
  logic [7:0] tx_r;         // Transmit shifter
  logic       byte_done_r;  // Eighth bit seen, act on next clock fall
  logic [6:0] ptr_r;        // Register pointer
  logic       autoinc_r;    // Page mode active for this transfer
  logic       sda_oe_r;     // Data pull-down

  // Control byte strobes and contents
  logic       wr_ch;        // Write channel_control_settings
  logic       wr_sys;       // Write system_control_settings
  logic [7:0] first_control_byte;   // channel_control_settings
  logic [7:0] second_control_byte;  // system_control_settings

  // Power-up state
  pwr_state_t pwr_r;         // Start-up sequencer
  logic       port_live;     // Serial port allowed to answer
  logic       ripple_chg_r;  // Ripple charge drive
  logic       amp_run_r;     // Operation flag
  logic       clip_oe_r;     // Clip pin pull-down
  logic       clip_src;      // Selected detector for the clip pin

  // Start and stop qualify on data edges while the clock is high
  logic start_cond;
  logic stop_cond;
  assign start_cond = sda_fall & scl_lvl;
  assign stop_cond  = sda_rise & scl_lvl;

  pin_edge_track u_scl (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin_in  (scl_in),
    .level   (scl_lvl),
    .rise    (scl_rise),
    .fall    (scl_fall)
  );

  pin_edge_track u_sda (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin_in  (sda_in),
    .level   (sda_lvl),
    .rise    (sda_rise),
    .fall    (sda_fall)
  );

  // Stored data byte goes to the register the pointer names
  assign wr_ch  = (bus_r == BUS_DATA) && byte_done_r && scl_fall &&
                  (ptr_r == SUB_CHANNEL_CTRL);
  assign wr_sys = (bus_r == BUS_DATA) && byte_done_r && scl_fall &&
                  (ptr_r == SUB_SYSTEM_CTRL);

  ctrl_byte_reg u_channel_ctrl (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wr_en   (wr_ch),
    .wr_data (shift_r),
    .value   (first_control_byte)
  );

  ctrl_byte_reg u_system_ctrl (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wr_en   (wr_sys),
    .wr_data (shift_r),
    .value   (second_control_byte)
  );

  // Setting outputs come straight from the control byte flops
  assign clip_thresh_10pct = first_control_byte[CH_CLIP_10PCT];
  assign rear_play         = first_control_byte[CH_REAR_PLAY];
  assign front_play        = first_control_byte[CH_FRONT_PLAY];
  assign rear_gain_12db    = first_control_byte[CH_REAR_GAIN12];
  assign front_gain_12db   = first_control_byte[CH_FRONT_GAIN12];
  assign offset_det_en     = first_control_byte[CH_OFFSET_EN];
  assign diag_cycle_en     = first_control_byte[CH_DIAG_EN];
  assign turnon_repeat     = first_control_byte[CH_TURNON_REPEAT];
  assign fast_mute         = second_control_byte[SYS_FAST_MUTE];

  // The port is deaf while the logic supply is down
  assign port_live = (pwr_r != PWR_HW_STANDBY);

  // Serial engine: address match, sub-address, data and read-back
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bus_r       <= BUS_IDLE;
      ack_next_r  <= BUS_IDLE;
      bit_cnt_r   <= BIT_CNT_ZERO;
      shift_r     <= CTRL_RESET_VAL;
      tx_r        <= CTRL_RESET_VAL;
      byte_done_r <= 1'b0;
      ptr_r       <= 7'h00;
      autoinc_r   <= 1'b0;
      sda_oe_r    <= 1'b0;
    end else if (!port_live) begin
      // Hardware standby: never touch the bus
      bus_r    <= BUS_IDLE;
      sda_oe_r <= 1'b0;
    end else if (stop_cond) begin
      // Stop ends any transfer and frees the data line
      bus_r       <= BUS_IDLE;
      sda_oe_r    <= 1'b0;
      byte_done_r <= 1'b0;
    end else if (start_cond) begin
      // Start or repeated start always restarts address reception
      bus_r       <= BUS_ADDR;
      bit_cnt_r   <= BIT_CNT_ZERO;
      byte_done_r <= 1'b0;
      sda_oe_r    <= 1'b0;
    end else begin
      case (bus_r)
        BUS_ADDR, BUS_SUB, BUS_DATA: begin
          if (scl_rise && !byte_done_r) begin
            // Sample data on the clock rise, most significant first
            shift_r   <= {shift_r[6:0], sda_lvl};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == BIT_CNT_LAST) begin
              byte_done_r <= 1'b1;
            end
          end else if (scl_fall && byte_done_r) begin
            byte_done_r <= 1'b0;
            bit_cnt_r   <= BIT_CNT_ZERO;
            if (bus_r == BUS_ADDR) begin
              if (shift_r[7:1] == DEV_ADDR7) begin
                sda_oe_r   <= 1'b1;
                bus_r      <= BUS_ACK;
                ack_next_r <= shift_r[0] ? BUS_TX : BUS_SUB;
              end else begin
                // Another device is addressed
                bus_r <= BUS_IGNORE;
              end
            end else if (bus_r == BUS_SUB) begin
              ptr_r      <= shift_r[6:0];
              autoinc_r  <= shift_r[SUB_AUTOINC_BIT];
              sda_oe_r   <= 1'b1;
              bus_r      <= BUS_ACK;
              ack_next_r <= BUS_DATA;
            end else if ((ptr_r == SUB_CHANNEL_CTRL) || (ptr_r == SUB_SYSTEM_CTRL)) begin
              // Mapped byte was stored this cycle; acknowledge it
              sda_oe_r   <= 1'b1;
              bus_r      <= BUS_ACK;
              ack_next_r <= BUS_DATA;
              if (autoinc_r) begin
                ptr_r <= ptr_r + 7'h01;
              end
            end else begin
              // Unmapped pointer: leave the byte unacknowledged
              bus_r <= BUS_IGNORE;
            end
          end
        end
        BUS_ACK: begin
          if (scl_fall) begin
            bus_r <= ack_next_r;
            if (ack_next_r == BUS_TX) begin
              // Read-back byte: run state and diagnosis enable
              tx_r     <= {amp_run_r, first_control_byte[CH_DIAG_EN], 6'h00};
              sda_oe_r <= ~amp_run_r;
            end else begin
              sda_oe_r <= 1'b0;
            end
          end
        end
        BUS_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == BIT_CNT_LAST) begin
              // Hand the line to the master for its acknowledge
              sda_oe_r  <= 1'b0;
              bit_cnt_r <= BIT_CNT_ZERO;
              bus_r     <= BUS_RACK;
            end else begin
              tx_r      <= {tx_r[6:0], 1'b0};
              sda_oe_r  <= ~tx_r[6];
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end
          end
        end
        BUS_RACK: begin
          if (scl_rise) begin
            // Master not acknowledging ends the read
            if (sda_lvl) begin
              bus_r <= BUS_IGNORE;
            end else begin
              byte_done_r <= 1'b1;
            end
          end else if (scl_fall && byte_done_r) begin
            byte_done_r <= 1'b0;
            tx_r        <= {amp_run_r, first_control_byte[CH_DIAG_EN], 6'h00};
            sda_oe_r    <= ~amp_run_r;
            bus_r       <= BUS_TX;
          end
        end
        BUS_IDLE, BUS_IGNORE: begin
          // Wait for the next start condition
          sda_oe_r <= 1'b0;
        end
        default: begin
          bus_r    <= BUS_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Start-up sequencer: hardware standby, software standby, charge, run
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pwr_r <= PWR_HW_STANDBY;
    end else begin
      case (pwr_r)
        PWR_HW_STANDBY: begin
          // Host raises the clip pin to wake the logic supply
          if (clip_pin_in) begin
            pwr_r <= PWR_SW_STANDBY;
          end
        end
        PWR_SW_STANDBY: begin
          if (second_control_byte[SYS_STANDBY_OFF]) begin
            pwr_r <= PWR_CHARGE;
          end
        end
        PWR_CHARGE: begin
          if (!second_control_byte[SYS_STANDBY_OFF]) begin
            pwr_r <= PWR_SW_STANDBY;
          end else if (ripple_at_target) begin
            pwr_r <= PWR_RUN;
          end
        end
        PWR_RUN: begin
          // Standby back on drops to software standby; logic stays up
          if (!second_control_byte[SYS_STANDBY_OFF]) begin
            pwr_r <= PWR_SW_STANDBY;
          end
        end
        default: begin
          pwr_r <= PWR_HW_STANDBY;
        end
      endcase
    end
  end

  // Power outputs follow the sequencer one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ripple_chg_r <= 1'b0;
      amp_run_r    <= 1'b0;
    end else begin
      ripple_chg_r <= (pwr_r == PWR_CHARGE) || (pwr_r == PWR_RUN);
      amp_run_r    <= (pwr_r == PWR_RUN);
    end
  end

  // Detector choice for the clip pin: clip or offset
  assign clip_src = second_control_byte[SYS_CLIP_TO_OFS] ? offset_event : clip_event;

  // Clip pin is an input until start-up is over, then an open-drain flag.
  // Holding it released before run keeps us from fighting the host's drive.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      clip_oe_r <= 1'b0;
    end else begin
      clip_oe_r <= amp_run_r && clip_src;
    end
  end

  assign sda_out       = 1'b0;
  assign sda_oe        = sda_oe_r;
  assign clip_pin_out  = 1'b0;
  assign clip_pin_oe   = clip_oe_r;
  assign ripple_charge = ripple_chg_r;
  assign amp_run       = amp_run_r;
endmodule
`default_nettype wire

// *** verification/amp_ctrl_monitor.sv ***
// Checker: port relations of the amplifier control port
`timescale 1ns/100ps
`default_nettype none
module amp_ctrl_monitor (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic clip_pin_in,
  input wire logic clip_pin_oe,
  input wire logic clip_event,
  input wire logic offset_event,
  input wire logic ripple_at_target,
  input wire logic ripple_charge,
  input wire logic amp_run,
  input wire logic clip_thresh_10pct,
  input wire logic rear_play,
  input wire logic front_play,
  input wire logic rear_gain_12db,
  input wire logic front_gain_12db,
  input wire logic offset_det_en,
  input wire logic diag_cycle_en,
  input wire logic turnon_repeat,
  input wire logic fast_mute
);
  logic       live_r;  // Clip pin seen powered since reset
  wire  [7:0] ch_w = {turnon_repeat, diag_cycle_en, offset_det_en, front_gain_12db,
                      rear_gain_12db, front_play, rear_play, clip_thresh_10pct};

  // Sticky record of the logic supply; only a reset clears it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      live_r <= 1'b0;
    end else if (clip_pin_in) begin
      live_r <= 1'b1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Ripple charging with the node at target
  sequence s_armed;
    ripple_charge && ripple_at_target;
  endsequence

  a_standby_quiet: assert property (!live_r |-> !sda_oe && !ripple_charge)
    else $error("port active before clip pin powered");
  a_ack_hold: assert property ($rose(sda_oe) |-> sda_oe[*3])
    else $error("data pull released too early");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data pull changed while bus clock high");
  a_ch_at_ack: assert property ($changed(ch_w) |-> sda_oe)
    else $error("channel settings changed outside an acknowledged byte");
  a_mute_at_ack: assert property ($changed(fast_mute) |-> sda_oe)
    else $error("fast mute changed outside an acknowledged byte");
  a_run_after: assert property (s_armed |-> ##[0:3] amp_run)
    else $error("run not reached after ripple target");
  a_run_charge: assert property (amp_run |-> ripple_charge)
    else $error("running without ripple charge");
  a_run_cause: assert property ($rose(amp_run) |-> $past(ripple_at_target))
    else $error("run started before ripple target");
  a_clip_idle: assert property (!$past(amp_run) |-> !clip_pin_oe)
    else $error("clip pin pulled before full operation");
  a_clip_follow: assert property ($past(amp_run && clip_event && offset_event) |-> clip_pin_oe)
    else $error("clip flag not shown on clip pin");
  a_clip_quiet: assert property ($past(!clip_event && !offset_event) |-> !clip_pin_oe)
    else $error("clip pin pulled without a detector event");
endmodule
`default_nettype wire

// *** verification/host_master_model.sv ***
// Partner: host controller acting as two-wire bus master
`timescale 1ns/100ps
`default_nettype none
module host_master_model (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda_drv,
  output var logic  clip_pwr
);
  // Bus idles released high; clock stands still outside frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    clip_pwr = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Power the clip pin before any transfer
  task automatic power_up;
    @(posedge clk_sys);
    clip_pwr <= 1'b1;
    tk(2);
  endtask

  // One bit: 5 clk low, 4 clk high, sampled just before the fall
  task automatic bit_io(input logic b, output logic seen);
    sda_drv <= b;
    tk(4);
    scl <= 1'b1;
    tk(4);
    seen = sda_line;
    scl <= 1'b0;
    tk(1);
  endtask

  // Byte out, then release the line for the acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic start;
    @(posedge clk_sys);
    sda_drv <= 1'b0;
    tk(4);
    scl <= 1'b0;
    tk(1);
  endtask

  task automatic stop;
    sda_drv <= 1'b0;
    tk(4);
    scl <= 1'b1;
    tk(4);
    sda_drv <= 1'b1;
    tk(4);
  endtask

  // Write frame of n bytes; counts acknowledged bytes
  task automatic wr(input logic [7:0] q[5], input int n, output int acks);
    logic k;
    acks = 0;
    start();
    for (int i = 0; i < n; i++) begin
      send(q[i], k);
      if (k) acks++;
    end
    stop();
  endtask

  // Read frame of one byte, ended by a not-acknowledge
  task automatic rd(output int acks, output logic [7:0] d);
    logic k;
    start();
    send(8'hD9, k);
    acks = k;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, k);
    stop();
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Testbench: host writes, start-up and read-back of the amplifier control port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import amp_ctrl_pkg::*;
  logic       clk_sys = 1'b0;           // 10 MHz clock
  logic       rstn = 1'b0;              // Held low for 16 cycles
  logic       clip_event = 1'b0;        // Detector stimulus
  logic       offset_event = 1'b0;
  logic       ripple_at_target = 1'b0;
  logic       scl, sda_drv, clip_pwr;   // Host model outputs
  logic       sda_out, sda_oe, clip_pin_out, clip_pin_oe, ripple_charge, amp_run, fast_mute;
  logic       clip_thresh_10pct, rear_play, front_play, rear_gain_12db;
  logic       front_gain_12db, offset_det_en, diag_cycle_en, turnon_repeat;
  logic [7:0] rd_d;                     // Read-back byte
  int         acks;                     // Acknowledged bytes of a frame
  int         fail_count = 0;
  int         tests_run = 0;
  // Pull-ups: a line is low only while someone pulls it
  wire        sda_line = sda_drv & ~(sda_oe & ~sda_out);
  wire        clip_pin_in = clip_pwr & ~(clip_pin_oe & ~clip_pin_out);
  wire  [7:0] ch_bits = {turnon_repeat, diag_cycle_en, offset_det_en, front_gain_12db,
                         rear_gain_12db, front_play, rear_play, clip_thresh_10pct};

  always #50 clk_sys = ~clk_sys;

  amp_i2c_control_port amp_i2c_control_port_inst (
    .clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .clip_pin_in(clip_pin_in), .clip_pin_out(clip_pin_out),
    .clip_pin_oe(clip_pin_oe), .clip_event(clip_event), .offset_event(offset_event),
    .ripple_at_target(ripple_at_target), .ripple_charge(ripple_charge), .amp_run(amp_run),
    .clip_thresh_10pct(clip_thresh_10pct), .rear_play(rear_play), .front_play(front_play),
    .rear_gain_12db(rear_gain_12db), .front_gain_12db(front_gain_12db),
    .offset_det_en(offset_det_en), .diag_cycle_en(diag_cycle_en),
    .turnon_repeat(turnon_repeat), .fast_mute(fast_mute));

  host_master_model host_master_model_inst (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv), .clip_pwr(clip_pwr));

  task automatic summarize;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask

  // Bounded wait for amp_run; running out ends the run
  task automatic settle_run(input logic want);
    for (int i = 0; i < 10 && amp_run !== want; i++) @(negedge clk_sys);
    if (amp_run !== want) begin
      fail_count++;
      summarize();
    end
  endtask

  task automatic t_hw_standby;
    host_master_model_inst.wr('{8'hD8, 8'h01, 8'hFF, 8'h00, 8'h00}, 3, acks);
    @(negedge clk_sys);
    chk("standby acks", 8'h00, acks[7:0]);
    chk("standby bits", 8'h00, ch_bits);
    host_master_model_inst.power_up();
  endtask

  task automatic t_wrong_addr;
    host_master_model_inst.wr('{8'hDA, 8'h01, 8'hFF, 8'h00, 8'h00}, 3, acks);
    @(negedge clk_sys);
    chk("foreign acks", 8'h00, acks[7:0]);
    chk("foreign bits", 8'h00, ch_bits);
  endtask

  // Walk one bit through the first control byte
  task automatic t_bits;
    for (int i = 0; i < 8; i++) begin
      host_master_model_inst.wr('{8'hD8, 8'h01, 8'h01 << i, 8'h00, 8'h00}, 3, acks);
      @(negedge clk_sys);
      chk("bit acks", 8'h03, acks[7:0]);
      chk("bit map", 8'h01 << i, ch_bits);
    end
  endtask

  // Page mode fills both bytes, then falls off the map
  task automatic t_page_mode;
    host_master_model_inst.wr('{8'hD8, 8'h81, 8'hA5, 8'h50, 8'h33}, 5, acks);
    @(negedge clk_sys);
    chk("page acks", 8'h04, acks[7:0]);
    chk("page first", 8'hA5, ch_bits);
    chk("page mute", 8'h01, {7'h00, fast_mute});
    chk("charge", 8'h01, {7'h00, ripple_charge});
    host_master_model_inst.wr('{8'hD8, 8'h01, 8'h3C, 8'hC3, 8'h00}, 4, acks);
    @(negedge clk_sys);
    chk("flat acks", 8'h04, acks[7:0]);
    chk("flat rewrite", 8'hC3, ch_bits);
    chk("flat mute", 8'h01, {7'h00, fast_mute});
  endtask

  // Ripple target, clip pin duty, read-back, back to standby
  task automatic t_startup;
    @(posedge clk_sys);
    ripple_at_target <= 1'b1;
    settle_run(1'b1);
    // Offset alone must leave the pin free while it reports clipping
    @(posedge clk_sys);
    offset_event <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("clip on offset", 8'h01, {7'h00, clip_pin_in});
    @(posedge clk_sys);
    clip_event <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("clip pulled", 8'h00, {7'h00, clip_pin_in});
    @(posedge clk_sys);
    clip_event <= 1'b0;
    offset_event <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("clip freed", 8'h01, {7'h00, clip_pin_in});
    host_master_model_inst.rd(acks, rd_d);
    @(negedge clk_sys);
    chk("read ack", 8'h01, acks[7:0]);
    chk("read byte", 8'hC0, rd_d);
    host_master_model_inst.wr('{8'hD8, 8'h02, 8'h00, 8'h00, 8'h00}, 3, acks);
    settle_run(1'b0);
    chk("charge off", 8'h00, {6'h00, ripple_charge, fast_mute});
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk("reset bits", 8'h00, ch_bits);
    chk("reset sys", 8'h00, {3'h0, fast_mute, amp_run, ripple_charge, sda_oe, clip_pin_oe});
    t_hw_standby();
    t_wrong_addr();
    t_bits();
    t_page_mode();
    t_startup();
    // Mid-run reset clears the written settings again
    host_master_model_inst.wr('{8'hD8, 8'h01, 8'hFF, 8'h00, 8'h00}, 3, acks);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk("rereset bits", 8'h00, ch_bits);
    summarize();
  end
endmodule

bind amp_i2c_control_port amp_ctrl_monitor amp_ctrl_monitor_inst (
  .clk_sys(clk_sys), .rstn(rstn), .scl_in(scl_in), .sda_oe(sda_oe), .clip_pin_in(clip_pin_in),
  .clip_pin_oe(clip_pin_oe), .clip_event(clip_event), .offset_event(offset_event),
  .ripple_at_target(ripple_at_target), .ripple_charge(ripple_charge), .amp_run(amp_run),
  .clip_thresh_10pct(clip_thresh_10pct), .rear_play(rear_play), .front_play(front_play),
  .rear_gain_12db(rear_gain_12db), .front_gain_12db(front_gain_12db),
  .offset_det_en(offset_det_en), .diag_cycle_en(diag_cycle_en),
  .turnon_repeat(turnon_repeat), .fast_mute(fast_mute));
`default_nettype wire
